//--- verilog/crr_reporter.sv
// Completion record reporter: numeric exception handling and record assembly.
`include "crr_map.svh"

module crr_reporter
  import crr_pkg::*;
#(
  parameter bit FAULT_INFO_SUPPORT = 1'b1,
  parameter int ADDR_W             = 8
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Software register port.
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // ALU element path.
  input  wire logic              elem_valid,
  input  crr_elem_type           elem_in,
  output logic                   elem_out_valid,
  output logic      [31:0]       elem_out_value,
  output logic      [3:0]        elem_out_flags,
  // Completion requests.
  input  wire logic              cmp_valid,
  output logic                   cmp_ready,
  input  crr_req_type            cmp_req,
  // Destination write path is empty of outstanding writes.
  input  wire logic              dst_writes_idle,
  // Record writes toward host memory.
  output logic                   mem_valid,
  input  wire logic              mem_ready,
  output crr_mem_type            mem_wr
);

  // Software control and observation state.
  logic [31:0]   ctrl_ff;
  logic [31:0]   rec_count_ff;
  logic [31:0]   reg_rdata_ff;
  // Element path state.
  logic          elem_out_valid_ff;
  logic [31:0]   elem_out_value_ff;
  logic [3:0]    elem_out_flags_ff;
  logic [3:0]    acc_flags_ff;
  // Record writer state.
  crr_state_type state_ff;
  crr_state_type nxt_state;
  crr_req_type   req_ff;
  logic [3:0]    rec_flags_ff;
  logic [63:0]   beat0_ff;
  logic [63:0]   beat1_ff;
  logic [63:0]   beat2_ff;
  logic [63:0]   beat3_ff;
  // Combinational element results.
  logic [31:0]   nxt_value;
  logic [3:0]    nxt_flags;
  logic          fmt_ok;
  logic          fmt_int;
  logic [31:0]   v_inf;
  logic [31:0]   v_max;
  logic [31:0]   v_nan;
  logic [31:0]   v_sign;
  logic [31:0]   v_mask;
  logic [31:0]   v_smin;
  // Combinational record fields.
  logic [5:0]    rec_code;
  logic [7:0]    rec_status;
  logic [7:0]    rec_result;
  logic [7:0]    rec_finfo;
  logic [31:0]   rec_bytes;
  logic [63:0]   rec_faddr;
  logic [23:0]   rec_inv;
  logic          page_fault;
  logic          xlat_fault;
  logic          accept;

  // Per-format constants; an undefined format code marks the operand invalid.
  always_comb begin
    fmt_ok  = 1'b1;
    fmt_int = 1'b0;
    v_inf   = 32'h0000_0000;
    v_max   = 32'h0000_0000;
    v_nan   = 32'h0000_0000;
    v_sign  = 32'h0000_0000;
    v_mask  = 32'hffff_ffff;
    v_smin  = 32'h0000_0000;
    unique case (elem_in.fmt)
      CRR_FP32: begin
        v_inf  = 32'h7f80_0000;
        v_max  = 32'h7f7f_ffff;
        v_nan  = 32'h7fc0_0000;
        v_sign = 32'h8000_0000;
      end
      CRR_FP16: begin
        v_inf  = 32'h0000_7c00;
        v_max  = 32'h0000_7bff;
        v_nan  = 32'h0000_7e00;
        v_sign = 32'h0000_8000;
        v_mask = 32'h0000_ffff;
      end
      CRR_BF16: begin
        v_inf  = 32'h0000_7f80;
        v_max  = 32'h0000_7f7f;
        v_nan  = 32'h0000_7fc0;
        v_sign = 32'h0000_8000;
        v_mask = 32'h0000_ffff;
      end
      CRR_FP8_E5M2: begin
        v_inf  = 32'h0000_007c;
        v_max  = 32'h0000_007b;
        v_nan  = 32'h0000_007e;
        v_sign = 32'h0000_0080;
        v_mask = 32'h0000_00ff;
      end
      CRR_EIGHT_BIT_FLOAT_FOUR_EXPONENT: begin
        // This format has no infinity, so the NaN code stands in for it.
        v_inf  = 32'h0000_007f;
        v_max  = 32'h0000_007e;
        v_nan  = 32'h0000_007f;
        v_sign = 32'h0000_0080;
        v_mask = 32'h0000_00ff;
      end
      CRR_INT8: begin
        fmt_int = 1'b1;
        v_mask  = 32'h0000_00ff;
        v_smin  = 32'h0000_0080;
      end
      CRR_INT16: begin
        fmt_int = 1'b1;
        v_mask  = 32'h0000_ffff;
        v_smin  = 32'h0000_8000;
      end
      CRR_INT32: begin
        fmt_int = 1'b1;
        v_smin  = 32'h8000_0000;
      end
      default: begin
        fmt_ok = 1'b0;
      end
    endcase
  end

  // Exception priority: invalid, then overflow, then underflow; the denormal operand flag is added alongside any of them.
  always_comb begin
    nxt_flags = 4'h0;
    nxt_value = elem_in.value & v_mask;
    if (!elem_in.denormals_as_zero_flag && elem_in.opnd_denormal && !fmt_int) begin
      // The ALU already rounded with the bounded exponent; only the flag is added.
      nxt_flags[`CRR_RES_DENORMAL] = 1'b1;
    end
    if (!fmt_ok || elem_in.opnd_nan || elem_in.inf_opposite_add) begin
      nxt_flags[`CRR_RES_INVALID] = 1'b1;
      nxt_value = v_nan;
    end else if (elem_in.overflow && fmt_int) begin
      nxt_flags[`CRR_RES_OVERFLOW] = 1'b1;
      if (!elem_in.saturate) begin
        nxt_value = elem_in.value & v_mask;
      end else if (!elem_in.is_signed) begin
        nxt_value = v_mask;
      end else if (elem_in.sign) begin
        nxt_value = v_smin;
      end else begin
        nxt_value = v_mask & ~v_smin;
      end
    end else if (elem_in.overflow) begin
      nxt_flags[`CRR_RES_OVERFLOW] = 1'b1;
      if (elem_in.sign && (elem_in.rnd == CRR_RND_NEGATIVE ||
                           elem_in.rnd == CRR_RND_NEAREST_EVEN)) begin
        nxt_value = v_inf | v_sign;
      end else if (!elem_in.sign && (elem_in.rnd == CRR_RND_POSITIVE ||
                                     elem_in.rnd == CRR_RND_NEAREST_EVEN)) begin
        nxt_value = v_inf;
      end else begin
        nxt_value = elem_in.sign ? (v_max | v_sign) : v_max;
      end
    end else if (elem_in.underflow && !fmt_int) begin
      nxt_flags[`CRR_RES_UNDERFLOW] = 1'b1;
      if (elem_in.flush_to_zero_flag) begin
        nxt_value = elem_in.sign ? v_sign : 32'h0000_0000;
      end
    end
  end

  // Element results leave from flip-flops one cycle after the element arrives.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      elem_out_valid_ff <= 1'b0;
      elem_out_value_ff <= 32'h0000_0000;
      elem_out_flags_ff <= 4'h0;
    end else begin
      elem_out_valid_ff <= elem_valid;
      if (elem_valid) begin
        elem_out_value_ff <= nxt_value;
        elem_out_flags_ff <= nxt_flags;
      end
    end
  end

  // Sticky result flags of the running compute operation; a new element in the
  // same cycle as the hand-off starts the next operation rather than being lost.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_flags_ff <= 4'h0;
    end else if (accept) begin
      acc_flags_ff <= elem_valid ? nxt_flags : 4'h0;
    end else if (elem_valid) begin
      acc_flags_ff <= acc_flags_ff | nxt_flags;
    end
  end

  // Status classification of the incoming request.
  assign page_fault = (cmp_req.op_status == `CRR_ST_PF_A) ||
                      (cmp_req.op_status == `CRR_ST_PF_B) ||
                      (cmp_req.op_status == `CRR_ST_PF_C) ||
                      (cmp_req.op_status == `CRR_ST_PF_D);
  assign xlat_fault = page_fault || (cmp_req.op_status == `CRR_ST_XLAT_FAULT);
  assign rec_result = cmp_req.is_compute ? {4'h0, acc_flags_ff} : cmp_req.op_result;

  // Record fields as they will be written.
  always_comb begin
    rec_code = cmp_req.op_status;
    if (cmp_req.is_compute && cmp_req.op_status == `CRR_ST_SUCCESS &&
        cmp_req.check_result && rec_result != 8'h00) begin
      rec_code = `CRR_ST_FALSE_PRED;
    end
    if (rec_code == 6'h00) begin
      // A zero code would look like a record that never arrived.
      rec_code = `CRR_ST_FALLBACK;
    end
    rec_status = {1'b0, 1'b0, rec_code};
    if (xlat_fault) begin
      rec_status[`CRR_ST_RW_BIT] = cmp_req.fault_write;
    end
    rec_finfo = 8'h00;
    if (page_fault && FAULT_INFO_SUPPORT) begin
      rec_finfo[`CRR_FI_OPND_MSB:`CRR_FI_OPND_LSB] = cmp_req.fault_opnd;
      rec_finfo[`CRR_FI_MASKED_BIT] = !cmp_req.fault_addr_valid;
    end
    // Undefined fields outside page faults are written as zero for repeatability.
    rec_bytes = 32'h0000_0000;
    if (page_fault && !cmp_req.full_done) begin
      rec_bytes = cmp_req.bytes_done;
    end
    rec_faddr = 64'h0000_0000_0000_0000;
    if (page_fault && (cmp_req.fault_addr_valid || !FAULT_INFO_SUPPORT)) begin
      rec_faddr = cmp_req.fault_addr;
      if (ctrl_ff[`CRR_CTRL_MASK_LOW]) begin
        rec_faddr[`CRR_ADDR_LOW_MSB:0] = 12'h000;
      end
    end
    rec_inv = 24'h00_0000;
    if (cmp_req.op_status == `CRR_ST_INV_FLAGS) begin
      rec_inv = cmp_req.invalid_flags;
      if (rec_inv == 24'h00_0000) begin
        rec_inv = 24'h00_0001;
      end
    end
  end

  // A request is taken only while idle and enabled.
  assign accept    = cmp_valid && cmp_ready;
  assign cmp_ready = (state_ff == CRR_IDLE) && ctrl_ff[`CRR_CTRL_ENABLE];

  // Capture the record once, so the request may change after the hand-off.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_ff       <= '0;
      rec_flags_ff <= 4'h0;
      beat0_ff     <= 64'h0000_0000_0000_0000;
      beat1_ff     <= 64'h0000_0000_0000_0000;
      beat2_ff     <= 64'h0000_0000_0000_0000;
      beat3_ff     <= 64'h0000_0000_0000_0000;
    end else if (accept) begin
      req_ff       <= cmp_req;
      rec_flags_ff <= acc_flags_ff;
      beat0_ff     <= {rec_bytes, 8'h00, rec_finfo, rec_result, rec_status};
      beat1_ff     <= rec_faddr;
      beat2_ff     <= {40'h00_0000_0000, rec_inv};
      beat3_ff     <= {32'h0000_0000,
                       cmp_req.has_bytes_written ? cmp_req.bytes_written : 32'h0000_0000};
    end
  end

  // Writer sequence: wait for destination writes, then offsets 8, 16, 24 and 0 last.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CRR_IDLE:  if (accept) nxt_state = CRR_DRAIN;
      CRR_DRAIN: if (dst_writes_idle) nxt_state = CRR_WR1;
      CRR_WR1:   if (mem_ready) nxt_state = CRR_WR2;
      CRR_WR2:   if (mem_ready) nxt_state = CRR_WR3;
      CRR_WR3:   if (mem_ready) nxt_state = CRR_WR0;
      CRR_WR0:   if (mem_ready) nxt_state = CRR_IDLE;
      default:   nxt_state = CRR_IDLE;
    endcase
  end

  // Writer state register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= CRR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Memory write beats; the base is forced onto a 32-byte boundary.
  always_comb begin
    mem_valid    = 1'b0;
    mem_wr.addr  = {req_ff.rec_addr[63:`CRR_REC_ALIGN_BITS], 5'h00};
    mem_wr.data  = beat0_ff;
    mem_wr.last  = 1'b0;
    unique case (state_ff)
      CRR_WR1: begin
        mem_valid   = 1'b1;
        mem_wr.addr = mem_wr.addr | 64'd`CRR_OFF_FAULT_ADDR;
        mem_wr.data = beat1_ff;
      end
      CRR_WR2: begin
        mem_valid   = 1'b1;
        mem_wr.addr = mem_wr.addr | 64'd`CRR_OFF_INV_FLAGS;
        mem_wr.data = beat2_ff;
      end
      CRR_WR3: begin
        mem_valid   = 1'b1;
        mem_wr.addr = mem_wr.addr | 64'd`CRR_OFF_BYTES_WRIT;
        mem_wr.data = beat3_ff;
      end
      CRR_WR0: begin
        mem_valid   = 1'b1;
        mem_wr.last = 1'b1;
      end
      default: begin
        mem_valid   = 1'b0;
      end
    endcase
  end

  // Control register written by software.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_ff <= `CRR_CTRL_RESET;
    end else if (reg_wr && reg_addr == ADDR_W'(`CRR_REG_CTRL)) begin
      ctrl_ff <= {30'h0, reg_wdata[1:0]};
    end
  end

  // Count of records fully written; a software write clears it, except in a cycle where a record completes, which increments it instead.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rec_count_ff <= 32'h0000_0000;
    end else if (state_ff == CRR_WR0 && mem_ready) begin
      rec_count_ff <= rec_count_ff + 32'h0000_0001;
    end else if (reg_wr && reg_addr == ADDR_W'(`CRR_REG_COUNT)) begin
      rec_count_ff <= 32'h0000_0000;
    end
  end

  // Read data appear in the cycle after the read strobe; unmapped words read zero.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_W'(`CRR_REG_CTRL):   reg_rdata_ff <= ctrl_ff;
        ADDR_W'(`CRR_REG_STATUS): reg_rdata_ff <= {24'h00_0000, rec_flags_ff,
                                                   acc_flags_ff[0], state_ff};
        ADDR_W'(`CRR_REG_CAP):    reg_rdata_ff <= {31'h0, FAULT_INFO_SUPPORT};
        ADDR_W'(`CRR_REG_COUNT):  reg_rdata_ff <= rec_count_ff;
        default:                  reg_rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end

  // Output drives.
  assign reg_rdata      = reg_rdata_ff;
  assign elem_out_valid = elem_out_valid_ff;
  assign elem_out_value = elem_out_value_ff;
  assign elem_out_flags = elem_out_flags_ff;

endmodule : crr_reporter

//--- verilog/crr_map.svh
// Offsets, field positions, codes and reset values of the completion record reporter.
`ifndef CRR_MAP_SVH
`define CRR_MAP_SVH

// Completion record geometry, in bytes.
`define CRR_REC_BYTES        32
`define CRR_REC_ALIGN_BITS   5
`define CRR_OFF_STATUS       0
`define CRR_OFF_RESULT       1
`define CRR_OFF_FAULT_INFO   2
`define CRR_OFF_BYTES_DONE   4
`define CRR_OFF_FAULT_ADDR   8
`define CRR_OFF_INV_FLAGS    16
`define CRR_OFF_BYTES_WRIT   24

// Field positions inside the record bytes.
`define CRR_ST_RW_BIT        7
`define CRR_ST_CODE_MSB      5
`define CRR_FI_OPND_MSB      3
`define CRR_FI_OPND_LSB      1
`define CRR_FI_MASKED_BIT    0
`define CRR_RES_UNDERFLOW    3
`define CRR_RES_OVERFLOW     2
`define CRR_RES_DENORMAL     1
`define CRR_RES_INVALID      0
`define CRR_ADDR_LOW_MSB     11

// Operation status codes.
`define CRR_ST_SUCCESS       6'h01
`define CRR_ST_FALSE_PRED    6'h02
`define CRR_ST_PF_A          6'h03
`define CRR_ST_PF_B          6'h04
`define CRR_ST_PF_C          6'h06
`define CRR_ST_INV_FLAGS     6'h10
`define CRR_ST_XLAT_FAULT    6'h1a
`define CRR_ST_PF_D          6'h1f
`define CRR_ST_FALLBACK      6'h3f

// Register map of the software port.
`define CRR_REG_CTRL         8'h00
`define CRR_REG_STATUS       8'h04
`define CRR_REG_CAP          8'h08
`define CRR_REG_COUNT        8'h0c
`define CRR_CTRL_ENABLE      0
`define CRR_CTRL_MASK_LOW    1
`define CRR_CTRL_RESET       32'h0000_0001

`endif

//--- verilog/crr_pkg.sv
// Types shared by the completion record reporter.
package crr_pkg;

  // Destination data formats of the element path.
  typedef enum logic [3:0] {
    CRR_FP32      = 4'h0,
    CRR_FP16      = 4'h1,
    CRR_BF16      = 4'h2,
    CRR_FP8_E5M2  = 4'h3,
    CRR_EIGHT_BIT_FLOAT_FOUR_EXPONENT  = 4'h4,
    CRR_INT8      = 4'h5,
    CRR_INT16     = 4'h6,
    CRR_INT32     = 4'h7
  } crr_fmt_type;

  // Rounding types.
  typedef enum logic [1:0] {
    CRR_RND_NEAREST_EVEN = 2'h0,
    CRR_RND_NEGATIVE     = 2'h1,
    CRR_RND_POSITIVE     = 2'h2,
    CRR_RND_ZERO         = 2'h3
  } crr_round_type;

  // Record writer states.
  typedef enum logic [2:0] {
    CRR_IDLE  = 3'h0,
    CRR_DRAIN = 3'h1,
    CRR_WR1   = 3'h2,
    CRR_WR2   = 3'h3,
    CRR_WR3   = 3'h4,
    CRR_WR0   = 3'h5
  } crr_state_type;

  // One ALU element with its exception classification.
  typedef struct packed {
    logic [3:0]    fmt;
    crr_round_type rnd;
    logic          flush_to_zero_flag;
    logic          denormals_as_zero_flag;
    logic          saturate;
    logic          is_signed;
    logic          sign;
    logic          overflow;
    logic          underflow;
    logic          opnd_denormal;
    logic          opnd_nan;
    logic          inf_opposite_add;
    logic [31:0]   value;
  } crr_elem_type;

  // One finished or stopped descriptor.
  typedef struct packed {
    logic [63:0] rec_addr;
    logic [5:0]  op_status;
    logic        fault_write;
    logic        is_compute;
    logic        check_result;
    logic [7:0]  op_result;
    logic [2:0]  fault_opnd;
    logic        fault_addr_valid;
    logic [63:0] fault_addr;
    logic [31:0] bytes_done;
    logic        full_done;
    logic        has_bytes_written;
    logic [31:0] bytes_written;
    logic [23:0] invalid_flags;
  } crr_req_type;

  // One 64-bit write toward host memory.
  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic        last;
  } crr_mem_type;

endpackage : crr_pkg

//--- test/crr_reporter_asserts.sv
// Port checker of the completion record reporter.
module crr_reporter_asserts
  import crr_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        rst,
  // Element path.
  input wire logic        elem_valid,
  input crr_elem_type     elem_in,
  input wire logic [31:0] elem_out_value,
  input wire logic [3:0]  elem_out_flags,
  // Record writes.
  input wire logic        dst_writes_idle,
  input wire logic        mem_valid,
  input wire logic        mem_ready,
  input crr_mem_type      mem_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Unsupported formats report invalid and never overflow or underflow, so the other flags are checked on known ones.
  wire logic ok = elem_valid && !elem_in.fmt[3];

  a_under_flag: assert property (ok && elem_in.underflow |=> elem_out_flags[3])
    else $error("underflow flag missing");
  a_over_flag: assert property (ok && elem_in.overflow |=> elem_out_flags[2])
    else $error("overflow flag missing");
  a_denorm_flag: assert property (ok && elem_in.opnd_denormal && !elem_in.denormals_as_zero_flag
    |=> elem_out_flags[1])
    else $error("denormal flag missing");
  a_inval_flag: assert property (elem_valid && (elem_in.opnd_nan || elem_in.inf_opposite_add
    || elem_in.fmt[3]) |=> elem_out_flags[0])
    else $error("invalid flag missing");
  // Only overflows that would round to infinity become a NaN; the others keep the largest finite.
  a_e4m3_nan: assert property (ok && elem_in.overflow && elem_in.fmt == CRR_EIGHT_BIT_FLOAT_FOUR_EXPONENT &&
    !elem_in.opnd_nan && !elem_in.inf_opposite_add && (elem_in.rnd == CRR_RND_NEAREST_EVEN ||
    elem_in.rnd == (elem_in.sign ? CRR_RND_NEGATIVE : CRR_RND_POSITIVE)) |=>
    elem_out_value[6:0] == 7'h7f && elem_out_value[7] == $past(elem_in.sign))
    else $error("short float overflow is not a signed NaN");
  a_beat_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_wr))
    else $error("record beat changed while stalled");
  a_beat_order: assert property (mem_valid && mem_ready && !mem_wr.last |=> mem_valid &&
    mem_wr.addr[4:0] == $past(mem_wr.addr[4:0]) + 5'h08)
    else $error("record beats out of order");
  a_first_beat: assert property ($rose(mem_valid) |-> mem_wr.addr[4:0] == 5'h08)
    else $error("record does not start after the status word");
  a_status_last: assert property (mem_valid && mem_wr.last |-> mem_wr.addr[4:0] == 5'h00)
    else $error("status word not written last");
  a_status_nonzero: assert property (mem_valid && mem_wr.last |-> mem_wr.data[5:0] != 6'h00)
    else $error("status written as zero");
  a_wait_dest: assert property ($rose(mem_valid) |-> $past(dst_writes_idle))
    else $error("record started before destination writes finished");
endmodule : crr_reporter_asserts

bind crr_reporter crr_reporter_asserts crr_reporter_asserts_inst (.clk_sys, .rst, .elem_valid,
  .elem_in, .elem_out_value, .elem_out_flags, .dst_writes_idle, .mem_valid, .mem_ready, .mem_wr);

//--- test/crr_host_mem.sv
// Host memory model that takes record beats and keeps the latest record.
module crr_host_mem
  import crr_pkg::*;
(
  // Clock and reset.
  input wire logic  clk_sys,
  input wire logic  rst,
  // Record beats.
  input wire logic  mem_valid,
  input crr_mem_type mem_wr,
  output logic      mem_ready,
  // Pace control.
  input wire logic  slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] rec [4];
  int          n_rec;
  logic        tog_ff;
  // A slow memory refuses every other cycle, so each beat must be held.
  assign mem_ready = !slow || tog_ff;
  // Software presets the status word to zero; the first beat of a record stands for that.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tog_ff <= 1'b0;
      n_rec  <= 0;
    end else begin
      tog_ff <= !tog_ff;
      if (mem_valid && mem_ready) begin
        rec[mem_wr.addr[4:3]] <= mem_wr.data;
        if (mem_wr.addr[4:3] == 2'h1) rec[0] <= 64'h0;
        if (mem_wr.last) n_rec <= n_rec + 1;
      end
    end
  end
endmodule : crr_host_mem

//--- test/crr_reporter_test.sv
// Self-checking bench of the completion record reporter.
`include "crr_map.svh"
module crr_reporter_test
  import crr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst, reg_wr, reg_rd, elem_valid, elem_out_valid, cmp_valid;
  logic        cmp_ready, dst_writes_idle, mem_valid, mem_ready, slow;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, elem_out_value;
  logic [3:0]  elem_out_flags;
  crr_elem_type elem_in;
  crr_req_type  cmp_req;
  crr_mem_type  mem_wr;
  int          mismatches, n_checks;
  // Row: format, rounding and exception bits, ALU value, expected value, flags, value checked.
  logic [87:0] rows [17] = '{
    88'h0_010_00000000_7f800000_4_1, 88'h0_c10_00000000_7f7fffff_4_1,
    88'h0_430_00000000_ff800000_4_1, 88'h0_830_00000000_ff7fffff_4_1,
    88'h1_810_00000000_00007c00_4_1, 88'h2_c30_00000000_0000ff7f_4_1,
    88'h3_010_00000000_0000007c_4_1, 88'h4_030_00000000_000000ff_4_1,
    88'h5_0f0_00000000_00000080_4_1, 88'h6_0d0_00000000_00007fff_4_1,
    88'h7_090_00000000_ffffffff_4_1, 88'h5_010_00001234_00000034_4_1,
    88'h0_228_00000000_80000000_8_1, 88'h0_004_3f800000_00000000_2_0,
    88'h0_002_7fc00000_00000000_1_0, 88'h0_001_00000000_00000000_1_0,
    88'h9_000_00000000_00000000_1_1};

  crr_reporter crr_reporter_inst (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .elem_valid, .elem_in, .elem_out_valid, .elem_out_value, .elem_out_flags,
    .cmp_valid, .cmp_ready, .cmp_req, .dst_writes_idle, .mem_valid, .mem_ready, .mem_wr);
  crr_host_mem crr_host_mem_inst (.clk_sys, .rst, .mem_valid, .mem_wr, .mem_ready, .slow);

  // Free-running system clock of 100 ns.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check(reg_rdata, e);
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Misaligned record base on purpose; the writer must round it down.
  function automatic crr_req_type mk(input logic [4:0] c, input logic [5:0] st,
    input logic [3:0] fo, input logic [63:0] fa, input logic [31:0] bd,
    input logic [31:0] bw, input logic [23:0] inv);
    return crr_req_type'({64'h2000_0047, st, c[4:2], 8'h5a, fo, fa, bd, c[1:0], bw, inv});
  endfunction : mk

  // Expected words that are all unknown mark fields left undefined for that status.
  task automatic run_cmp(input crr_req_type r, input logic [63:0] w0, w1, w2, w3);
    int k;
    int n0;
    k  = 0;
    n0 = crr_host_mem_inst.n_rec;
    @(posedge clk_sys);
    cmp_valid <= 1'b1;
    cmp_req   <= r;
    do begin
      @(negedge clk_sys);
      k++;
    end while (cmp_ready !== 1'b1 && k < 50);
    @(posedge clk_sys);
    cmp_valid <= 1'b0;
    while (crr_host_mem_inst.n_rec == n0 && k < 100) begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 100) begin
      mismatches++;
      finish_test();
    end
    check(crr_host_mem_inst.rec[0], w0);
    if (^w1 !== 1'bx) check(crr_host_mem_inst.rec[1], w1);
    if (^w2 !== 1'bx) check(crr_host_mem_inst.rec[2], w2);
    if (^w3 !== 1'bx) check(crr_host_mem_inst.rec[3], w3);
  endtask : run_cmp

  // Main sequence: reset, element rows, records, registers, second reset.
  initial begin
    {rst, reg_wr, reg_rd, elem_valid, cmp_valid, slow} = 6'h20;
    {reg_addr, reg_wdata, elem_in, cmp_req} = '0;
    dst_writes_idle = 1'b1;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check(cmp_ready, 1'b1);
    check(mem_valid, 1'b0);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      elem_valid <= 1'b1;
      elem_in    <= rows[i][87:40];
      @(posedge clk_sys);
      elem_valid <= 1'b0;
      @(negedge clk_sys);
      check(elem_out_valid, 1'b1);
      check(elem_out_flags, rows[i][7:4]);
      if (rows[i][0]) check(elem_out_value, rows[i][39:8]);
    end
    $display("element tests done");
    run_cmp(mk(5'h0e, 6'h01, 4'h0, 0, 32'h77, 0, 0), 64'h0f02, 'x, 'x, 'x);
    run_cmp(mk(5'h0e, 6'h01, 4'h0, 0, 32'h77, 0, 0), 64'h0001, 'x, 'x, 'x);
    run_cmp(mk(5'h10, 6'h03, 4'h7, 64'h1234_5678_9abc_def0, 32'h180, 0, 0),
      64'h0000_0180_0006_5a83, 64'h1234_5678_9abc_def0, 'x, 'x);
    wr(`CRR_REG_CTRL, 32'h3);
    slow <= 1'b1;
    run_cmp(mk(5'h00, 6'h1f, 4'hd, 64'h1234_5678_9abc_def0, 32'h40, 0, 0),
      64'h0000_0040_000c_5a1f, 64'h1234_5678_9abc_d000, 'x, 'x);
    @(posedge clk_sys);
    dst_writes_idle <= 1'b0;
    fork
      run_cmp(mk(5'h00, 6'h04, 4'ha, 64'h55aa, 32'h10, 0, 0),
        64'h0000_0010_000b_5a04, 64'h0, 'x, 'x);
      begin
        repeat (20) @(negedge clk_sys);
        check(mem_valid, 1'b0);
        @(posedge clk_sys);
        dst_writes_idle <= 1'b1;
      end
    join
    @(posedge clk_sys);
    slow <= 1'b0;
    run_cmp(mk(5'h10, 6'h1a, 4'h0, 0, 0, 0, 0), 64'h5a9a, 'x, 'x, 'x);
    run_cmp(mk(5'h10, 6'h06, 4'h3, 64'hff, 32'h8, 0, 0),
      64'h0000_0008_0002_5a86, 64'h0, 'x, 'x);
    run_cmp(mk(5'h00, 6'h10, 4'h0, 0, 0, 0, 0), 64'h5a10, 'x, 64'h1, 'x);
    run_cmp(mk(5'h00, 6'h10, 4'h0, 0, 0, 0, 24'ha40002), 64'h5a10, 'x, 64'ha40002, 'x);
    run_cmp(mk(5'h00, 6'h00, 4'h0, 0, 0, 0, 0), 64'h5a3f, 'x, 'x, 'x);
    run_cmp(mk(5'h03, 6'h01, 4'h0, 0, 32'h99, 32'h321, 0), 64'h5a01, 'x, 'x, 64'h321);
    $display("record tests done");
    rd(`CRR_REG_COUNT, 32'h0b);
    rd(`CRR_REG_CAP, 32'h1);
    rd(8'h20, 32'h0);
    wr(`CRR_REG_COUNT, 32'h0);
    rd(`CRR_REG_COUNT, 32'h0);
    wr(`CRR_REG_CTRL, 32'h0);
    @(negedge clk_sys);
    check(cmp_ready, 1'b0);
    $display("register tests done");
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    rd(`CRR_REG_CTRL, `CRR_CTRL_RESET);
    check(cmp_ready, 1'b1);
    $display("reset tests done");
    finish_test();
  end
endmodule : crr_reporter_test
